// file: logic/clrm_pkg.sv
package clrm_pkg;
   // Bus geometry; the printed offsets are byte addresses
   localparam int ADDR_W = 20;
   localparam logic [19:0] TRIG_OFS = 20'h2000c;
   localparam logic [19:0] DAC_OFS = 20'h20010;
   localparam logic [19:0] FMUX_OFS = 20'h20014;
   localparam logic [19:0] KCA_OFS = 20'h20018;
   localparam logic [19:0] KCB_OFS = 20'h2001c;

   // Trigger routing field positions (lowest bit of each controller group)
   localparam int TRIG_FE0_LSB = 0;
   localparam int TRIG_FE1_LSB = 4;
   localparam int TRIG_FE2_LSB = 8;

   // Setpoint source register field positions
   localparam int DAC_EN_LSB = 0;
   localparam int DAC0_SRC_LSB = 8;
   localparam int DAC1_SRC_LSB = 16;
   localparam int DAC2_SRC_LSB = 24;

   // Filter input select field positions
   localparam int F_IN_LSB = 0;
   localparam int F_PER_LSB = 8;
   localparam int F_FFWD_LSB = 16;
   localparam int F_K_LSB = 24;

   // Constant register field positions
   localparam int K0_LSB = 0;
   localparam int K1_LSB = 16;
   localparam int K2_LSB = 0;
   localparam int KC_W = 14;

   // Setpoint source codes
   localparam logic [2:0] SRC_CPOWER = 3'h3;
   localparam logic [2:0] SRC_FILT0 = 3'h4;

   // Reset values
   localparam logic [1:0] F0_IN_RST = 2'h0;
   localparam logic [1:0] F1_IN_RST = 2'h1;
   localparam logic [1:0] F2_IN_RST = 2'h2;
   localparam logic [13:0] K0_RST = 14'h007d;
   localparam logic [13:0] K1_RST = 14'h0000;
   localparam logic [13:0] K2_RST = 14'h0000;

   // Software visible routing state
   typedef struct packed {
      logic [11:0] trig_en;
      logic [2:0] dac2_setpoint_source;
      logic [2:0] dac1_setpoint_source;
      logic [2:0] dac0_setpoint_source;
      logic [2:0] dac_external_setpoint_enable;
      logic [5:0] filter_constant_select;
      logic [2:0] filter_feedforward_source;
      logic [5:0] filter_period_source;
      logic [5:0] filter_input_source;
      logic [13:0] period_constant_0;
      logic [13:0] period_constant_1;
      logic [13:0] period_constant_2;
   } clrm_regs_t;

   // Whole state of the block
   typedef struct packed {
      clrm_regs_t regs;
      logic ack;
      logic [31:0] rdata;
   } clrm_state_t;
endpackage

// file: logic/clrm_sel_mux.sv
`timescale 1ns/1ps
// Indexed selector; codes at or above N give zero so reserved codes are inert
module clrm_sel_mux #(
   parameter int N = 4,
   parameter int W = 16,
   parameter int SEL_W = 2
) (
   input wire logic [W-1:0] src [N],
   input wire logic [SEL_W-1:0] sel,
   output logic [W-1:0] out
);
   always_comb begin
      out = '0;
      for (int i = 0; i < N; i++) begin
         if (int'(sel) == i) begin
            out = src[i];
         end
      end
   end
endmodule

// file: logic/clrm_trig_gate.sv
`timescale 1ns/1ps
// One front-end trigger: any enabled modulator trigger passes
module clrm_trig_gate #(
   parameter int N = 4
) (
   input wire logic [N-1:0] trig_in,
   input wire logic [N-1:0] enable,
   output logic trig_out
);
   assign trig_out = |(trig_in & enable);
endmodule

// file: logic/clrm_top.sv
`timescale 1ns/1ps
// Operation
// - Bits 11..8 gate triggers of modulators 3..0 into front-end 2.
// - Bits 7..4 gate triggers of modulators 3..0 into front-end 1.
// - Bits 3..0 gate triggers of modulators 3..0 into front-end 0.
// - DAC enable bit set takes select field; clear takes own front-end.
// - DAC 2 field 26..24 picks DAC0, DAC1, power, filters 0..2.
// - DAC 1 field 18..16 picks DAC0, DAC2, power, filters 0..2.
// - DAC 0 field 10..8 picks DAC1, DAC2, power, filters 0..2.
// - Two-bit fields 29..24 route constant 0, 1 or 2 per filter.
// - Bit 18 feeds filter 2 from filter 0, or filter 1 when set.
// - Bit 17 feeds filter 1 from filter 0, or filter 2 when set.
// - Bit 16 feeds filter 0 from filter 1, or filter 2 when set.
// - Fields 13..8 choose modulator period 0..3 for each filter.
// - Fields 5..0 choose front-end data per filter; resets 2, 1, 0.
// - Constant 0 at 13..0, constant 1 at 29..16; constant 0 resets 0x7d.
// - Constant 2 sits in bits 13..0 of its own register.
module clrm_top #(
   parameter int DATA_W = 16,
   parameter int FE_W = 16,
   parameter int PER_W = 18
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [clrm_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [3:0] pwm_sample_trig,
   output logic [2:0] fe_trig_out,
   input wire logic [DATA_W-1:0] fe_setpoint [3],
   input wire logic [DATA_W-1:0] cpower_out,
   input wire logic [DATA_W-1:0] filter_out [3],
   input wire logic [FE_W-1:0] fe_data [3],
   input wire logic [PER_W-1:0] pwm_period [4],
   output logic [DATA_W-1:0] dac_setpoint [3],
   output logic [FE_W-1:0] filter_fe_data [3],
   output logic [PER_W-1:0] filter_period [3],
   output logic [DATA_W-1:0] filter_ffwd [3],
   output logic [clrm_pkg::KC_W-1:0] filter_kcomp [3]
);
   clrm_pkg::clrm_state_t st_q;
   clrm_pkg::clrm_state_t st_d;
   clrm_pkg::clrm_regs_t rg;
   logic req;
   logic [31:0] cur_word;
   logic [31:0] bmask;
   logic [31:0] new_word;

   assign rg = st_q.regs;
   assign req = avs_read | avs_write;

   // One wait state: the request is decoded, then answered
   assign avs_waitrequest = req & ~st_q.ack;
   assign avs_readdata = st_q.rdata;

   // Byte lane mask for partial writes
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         bmask[8*b +: 8] = {8{avs_byteenable[b]}};
      end
   end

   // Readback packing; bits outside any field stay zero
   always_comb begin
      cur_word = 32'h0000_0000;
      case (avs_address)
         clrm_pkg::TRIG_OFS: begin
            cur_word[11:0] = rg.trig_en;
         end
         clrm_pkg::DAC_OFS: begin
            cur_word[clrm_pkg::DAC_EN_LSB +: 3] =
               rg.dac_external_setpoint_enable;
            cur_word[clrm_pkg::DAC0_SRC_LSB +: 3] = rg.dac0_setpoint_source;
            cur_word[clrm_pkg::DAC1_SRC_LSB +: 3] = rg.dac1_setpoint_source;
            cur_word[clrm_pkg::DAC2_SRC_LSB +: 3] = rg.dac2_setpoint_source;
         end
         clrm_pkg::FMUX_OFS: begin
            cur_word[clrm_pkg::F_IN_LSB +: 6] = rg.filter_input_source;
            cur_word[clrm_pkg::F_PER_LSB +: 6] = rg.filter_period_source;
            cur_word[clrm_pkg::F_FFWD_LSB +: 3] =
               rg.filter_feedforward_source;
            cur_word[clrm_pkg::F_K_LSB +: 6] = rg.filter_constant_select;
         end
         clrm_pkg::KCA_OFS: begin
            cur_word[clrm_pkg::K0_LSB +: 14] = rg.period_constant_0;
            cur_word[clrm_pkg::K1_LSB +: 14] = rg.period_constant_1;
         end
         clrm_pkg::KCB_OFS: begin
            cur_word[clrm_pkg::K2_LSB +: 14] = rg.period_constant_2;
         end
         default: begin
            cur_word = 32'h0000_0000;
         end
      endcase
   end

   assign new_word = (cur_word & ~bmask) | (avs_writedata & bmask);

   // Next state: bus handshake and register writes
   always_comb begin
      st_d = st_q;
      st_d.ack = req & ~st_q.ack;
      if (req & ~st_q.ack) begin
         st_d.rdata = avs_read ? cur_word : 32'h0000_0000;
      end
      // Write lands on the edge where waitrequest is seen low
      if (avs_write & st_q.ack) begin
         case (avs_address)
            clrm_pkg::TRIG_OFS: begin
               st_d.regs.trig_en = new_word[11:0];
            end
            clrm_pkg::DAC_OFS: begin
               st_d.regs.dac_external_setpoint_enable =
                  new_word[clrm_pkg::DAC_EN_LSB +: 3];
               st_d.regs.dac0_setpoint_source =
                  new_word[clrm_pkg::DAC0_SRC_LSB +: 3];
               st_d.regs.dac1_setpoint_source =
                  new_word[clrm_pkg::DAC1_SRC_LSB +: 3];
               st_d.regs.dac2_setpoint_source =
                  new_word[clrm_pkg::DAC2_SRC_LSB +: 3];
            end
            clrm_pkg::FMUX_OFS: begin
               st_d.regs.filter_input_source =
                  new_word[clrm_pkg::F_IN_LSB +: 6];
               st_d.regs.filter_period_source =
                  new_word[clrm_pkg::F_PER_LSB +: 6];
               st_d.regs.filter_feedforward_source =
                  new_word[clrm_pkg::F_FFWD_LSB +: 3];
               st_d.regs.filter_constant_select =
                  new_word[clrm_pkg::F_K_LSB +: 6];
            end
            clrm_pkg::KCA_OFS: begin
               st_d.regs.period_constant_0 = new_word[clrm_pkg::K0_LSB +: 14];
               st_d.regs.period_constant_1 = new_word[clrm_pkg::K1_LSB +: 14];
            end
            clrm_pkg::KCB_OFS: begin
               st_d.regs.period_constant_2 = new_word[clrm_pkg::K2_LSB +: 14];
            end
            default: begin
               st_d.regs = st_q.regs; // Unmapped writes are dropped
            end
         endcase
      end
   end

   // State register with reset values
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_q <= '0;
         st_q.regs.filter_input_source <= {clrm_pkg::F2_IN_RST,
            clrm_pkg::F1_IN_RST, clrm_pkg::F0_IN_RST};
         st_q.regs.period_constant_0 <= clrm_pkg::K0_RST;
         st_q.regs.period_constant_1 <= clrm_pkg::K1_RST;
         st_q.regs.period_constant_2 <= clrm_pkg::K2_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // Trigger gating per front-end controller
   clrm_trig_gate #(.N(4)) u_trig0 (
      .trig_in(pwm_sample_trig),
      .enable(rg.trig_en[clrm_pkg::TRIG_FE0_LSB +: 4]),
      .trig_out(fe_trig_out[0])
   );
   clrm_trig_gate #(.N(4)) u_trig1 (
      .trig_in(pwm_sample_trig),
      .enable(rg.trig_en[clrm_pkg::TRIG_FE1_LSB +: 4]),
      .trig_out(fe_trig_out[1])
   );
   clrm_trig_gate #(.N(4)) u_trig2 (
      .trig_in(pwm_sample_trig),
      .enable(rg.trig_en[clrm_pkg::TRIG_FE2_LSB +: 4]),
      .trig_out(fe_trig_out[2])
   );

   // Setpoint sources; a DAC's own code is reserved and gives zero
   logic [DATA_W-1:0] sp_src [3][8];
   logic [2:0] sp_sel [3];
   logic [DATA_W-1:0] sp_mux [3];
   assign sp_sel[0] = rg.dac0_setpoint_source;
   assign sp_sel[1] = rg.dac1_setpoint_source;
   assign sp_sel[2] = rg.dac2_setpoint_source;

   // Loop through the other DACs' own setpoints avoids a routing cycle
   for (genvar n = 0; n < 3; n++) begin : g_dac
      always_comb begin
         for (int k = 0; k < 3; k++) begin
            sp_src[n][k] = (k == n) ? '0 : fe_setpoint[k];
            sp_src[n][k + 4] = filter_out[k];
         end
         sp_src[n][3] = cpower_out;
         sp_src[n][7] = '0;
      end
      clrm_sel_mux #(.N(8), .W(DATA_W), .SEL_W(3)) u_sp (
         .src(sp_src[n]),
         .sel(sp_sel[n]),
         .out(sp_mux[n])
      );
      assign dac_setpoint[n] = rg.dac_external_setpoint_enable[n] ?
         sp_mux[n] : fe_setpoint[n];
   end

   // Filter input routing; front-end code 3 and constant code 3 give zero
   logic [clrm_pkg::KC_W-1:0] kc_src [3];
   assign kc_src[0] = rg.period_constant_0;
   assign kc_src[1] = rg.period_constant_1;
   assign kc_src[2] = rg.period_constant_2;

   for (genvar f = 0; f < 3; f++) begin : g_filt
      clrm_sel_mux #(.N(3), .W(FE_W), .SEL_W(2)) u_fe (
         .src(fe_data),
         .sel(rg.filter_input_source[2*f +: 2]),
         .out(filter_fe_data[f])
      );
      clrm_sel_mux #(.N(4), .W(PER_W), .SEL_W(2)) u_per (
         .src(pwm_period),
         .sel(rg.filter_period_source[2*f +: 2]),
         .out(filter_period[f])
      );
      clrm_sel_mux #(.N(3), .W(clrm_pkg::KC_W), .SEL_W(2)) u_k (
         .src(kc_src),
         .sel(rg.filter_constant_select[2*f +: 2]),
         .out(filter_kcomp[f])
      );
   end

   // Feedforward: each filter picks one of the two others
   assign filter_ffwd[0] = rg.filter_feedforward_source[0] ?
      filter_out[2] : filter_out[1];
   assign filter_ffwd[1] = rg.filter_feedforward_source[1] ?
      filter_out[2] : filter_out[0];
   assign filter_ffwd[2] = rg.filter_feedforward_source[2] ?
      filter_out[1] : filter_out[0];

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   // Trigger gates: a set bit passes its modulator, clear bits block
   trig_fe2_a: assert property (
      pwm_sample_trig[3] && rg.trig_en[11] |-> fe_trig_out[2])
      else $error("fe2 trigger lost");
   trig_fe1_a: assert property (
      fe_trig_out[1] |-> |(pwm_sample_trig & rg.trig_en[7:4]))
      else $error("fe1 trigger spurious");
   trig_fe0_a: assert property (
      rg.trig_en[3:0] == 4'h0 |-> !fe_trig_out[0])
      else $error("fe0 trigger leaks");

   // Setpoint routing
   dac_own_a: assert property (
      !rg.dac_external_setpoint_enable[1]
      |-> dac_setpoint[1] == fe_setpoint[1])
      else $error("dac1 not from own");
   dac2_src_a: assert property (
      rg.dac_external_setpoint_enable[2]
      && rg.dac2_setpoint_source == 3'h5
      |-> dac_setpoint[2] == filter_out[1])
      else $error("dac2 wrong source");
   dac1_src_a: assert property (
      rg.dac_external_setpoint_enable[1]
      && rg.dac1_setpoint_source == 3'h2
      |-> dac_setpoint[1] == fe_setpoint[2])
      else $error("dac1 wrong source");
   dac0_src_a: assert property (
      rg.dac_external_setpoint_enable[0]
      && rg.dac0_setpoint_source == clrm_pkg::SRC_CPOWER
      |-> dac_setpoint[0] == cpower_out)
      else $error("dac0 wrong source");
   dac0_filt_a: assert property (
      rg.dac_external_setpoint_enable[0]
      && rg.dac0_setpoint_source == clrm_pkg::SRC_FILT0
      |-> dac_setpoint[0] == filter_out[0])
      else $error("dac0 filter source wrong");
   // A reserved code must not leak whatever sits behind it
   dac_rsvd_a: assert property (
      rg.dac_external_setpoint_enable[2]
      && rg.dac2_setpoint_source == 3'h7
      |-> dac_setpoint[2] == '0)
      else $error("dac2 reserved code routes data");

   // Filter routing
   kcomp_sel_a: assert property (
      rg.filter_constant_select[5:4] == 2'h2
      |-> filter_kcomp[2] == rg.period_constant_2)
      else $error("filter2 constant wrong");
   ffwd_f2_a: assert property (
      filter_ffwd[2] == (rg.filter_feedforward_source[2] ?
      filter_out[1] : filter_out[0]))
      else $error("filter2 feedforward wrong");
   ffwd_f1_a: assert property (
      !rg.filter_feedforward_source[1]
      |-> filter_ffwd[1] == filter_out[0])
      else $error("filter1 feedforward wrong");
   ffwd_f0_a: assert property (
      rg.filter_feedforward_source[0]
      |-> filter_ffwd[0] == filter_out[2])
      else $error("filter0 feedforward wrong");
   period_sel_a: assert property (
      rg.filter_period_source[3:2] == 2'h3
      |-> filter_period[1] == pwm_period[3])
      else $error("filter1 period wrong");
   fe_sel_a: assert property (
      rg.filter_input_source[1:0] == 2'h1
      |-> filter_fe_data[0] == fe_data[1])
      else $error("filter0 input wrong");
   fe_rsvd_a: assert property (
      rg.filter_input_source[3:2] == 2'h3
      |-> filter_fe_data[1] == '0)
      else $error("filter1 reserved input routes data");

   // Register storage and reset values
   reset_val_a: assert property (
      $fell(srst) |-> rg.filter_input_source == 6'h24
      && rg.period_constant_0 == clrm_pkg::K0_RST)
      else $error("reset values wrong");
   kc_read_a: assert property (
      avs_read && !st_q.ack && avs_address == clrm_pkg::KCA_OFS
      |=> avs_readdata == {2'h0, rg.period_constant_1, 2'h0,
      rg.period_constant_0}) else $error("constant readback");
   kca_lane_a: assert property (
      avs_write && st_q.ack && avs_address == clrm_pkg::KCA_OFS
      && avs_byteenable == 4'hc
      |=> rg.period_constant_0 == $past(rg.period_constant_0))
      else $error("masked lanes of constant 0 written");
   kcb_write_a: assert property (
      avs_write && st_q.ack && avs_address == clrm_pkg::KCB_OFS
      && avs_byteenable == 4'hf
      |=> rg.period_constant_2 == $past(avs_writedata[13:0]))
      else $error("constant 2 write lost");
   rsvd_zero_a: assert property (
      avs_read && !st_q.ack && avs_address == clrm_pkg::DAC_OFS
      |=> (avs_readdata & 32'hf8f8_f8f8) == 32'h0)
      else $error("reserved bits set");
   trig_write_a: assert property (
      avs_write && st_q.ack && avs_address == clrm_pkg::TRIG_OFS
      && avs_byteenable[1:0] == 2'h3
      |=> rg.trig_en == $past(avs_writedata[11:0]))
      else $error("trigger enables not written");

   // Bus timing: one wait state, and the answer lasts a single cycle
   wr_ack_a: assert property (
      avs_write && !st_q.ack |=> !avs_waitrequest)
      else $error("write answer late");
   ack_pulse_a: assert property (
      (avs_read || avs_write) && !avs_waitrequest
      |=> avs_waitrequest || !(avs_read || avs_write))
      else $error("answer held too long");

   cov_ext_dac_c: cover property (rg.dac_external_setpoint_enable == 3'h7);
   cov_trig_c: cover property (fe_trig_out == 3'h7);
   cov_period_constant_2_c: cover property (filter_kcomp[0] == rg.period_constant_2
      && rg.filter_constant_select[1:0] == 2'h2);
   cov_wr_c: cover property (avs_write && !avs_waitrequest);
   cov_rd_c: cover property (avs_read && !avs_waitrequest);
endmodule

// file: verification/clrm_far_model.sv
`timescale 1ns/1ps
// Far-side sources: front ends, filters, power module and modulators
module clrm_far_model #(
   parameter int DATA_W = 16,
   parameter int FE_W = 16,
   parameter int PER_W = 18
) (
   input wire logic [3:0] trig_req,
   output logic [3:0] pwm_sample_trig,
   output logic [DATA_W-1:0] fe_setpoint [3],
   output logic [DATA_W-1:0] cpower_out,
   output logic [DATA_W-1:0] filter_out [3],
   output logic [FE_W-1:0] fe_data [3],
   output logic [PER_W-1:0] pwm_period [4]
);
   // Distinct value per source so a wrong route never looks right
   assign pwm_sample_trig = trig_req;
   assign cpower_out = DATA_W'(16'h3c3c);
   for (genvar i = 0; i < 3; i++) begin : g_src
      assign fe_setpoint[i] = DATA_W'(16'h1a00 + i);
      assign filter_out[i] = DATA_W'(16'h4b00 + i);
      assign fe_data[i] = FE_W'(16'h5d00 + i);
   end
   // Periods near full width to catch a truncated path
   for (genvar i = 0; i < 4; i++) begin : g_per
      assign pwm_period[i] = PER_W'(18'h2e000 + i);
   end
endmodule

// file: verification/clrm_top_test.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
$display("unexpected at %0t: got %h want %h", $time, g, e); end end
module clrm_top_test;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic [19:0] avs_address = 20'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [3:0] trig_req = 4'h0;
   logic [3:0] pwm_sample_trig;
   logic [2:0] fe_trig_out;
   logic [15:0] fe_setpoint [3];
   logic [15:0] cpower_out;
   logic [15:0] filter_out [3];
   logic [15:0] fe_data [3];
   logic [17:0] pwm_period [4];
   logic [15:0] dac_setpoint [3];
   logic [15:0] filter_fe_data [3];
   logic [17:0] filter_period [3];
   logic [15:0] filter_ffwd [3];
   logic [13:0] filter_kcomp [3];
   int n_mismatch = 0;
   int n_tests = 0;
   logic [31:0] q;
   logic [19:0] ra [5];
   logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h24, 32'h7d, 32'h0};
   logic [31:0] rm [5] = '{32'hfff, 32'h07070707, 32'h3f073f3f,
      32'h3fff3fff, 32'h3fff};

   clrm_top clrm_top_i (.ref_clk(ref_clk), .srst(srst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .pwm_sample_trig(pwm_sample_trig),
      .fe_trig_out(fe_trig_out), .fe_setpoint(fe_setpoint),
      .cpower_out(cpower_out), .filter_out(filter_out), .fe_data(fe_data),
      .pwm_period(pwm_period), .dac_setpoint(dac_setpoint),
      .filter_fe_data(filter_fe_data), .filter_period(filter_period),
      .filter_ffwd(filter_ffwd), .filter_kcomp(filter_kcomp));
   clrm_far_model clrm_far_model_i (.trig_req(trig_req),
      .pwm_sample_trig(pwm_sample_trig), .fe_setpoint(fe_setpoint),
      .cpower_out(cpower_out), .filter_out(filter_out), .fe_data(fe_data),
      .pwm_period(pwm_period));

   // 40 MHz clock
   initial begin
      forever #12.5 ref_clk = ~ref_clk;
   end

   // One Avalon access; held until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [19:0] a,
                      input logic [31:0] d, input logic [3:0] be);
      @(posedge ref_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= d;
      avs_byteenable <= be;
      // No fixed latency is assumed; only the watchdog ends a hang
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge ref_clk);
      end
      // Answer taken at the edge that sees waitrequest low, then released
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   // Routed outputs are looked at once the new selection has landed
   task automatic wr(input logic [19:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hf);
      @(negedge ref_clk);
   endtask

   task automatic rd_chk(input logic [19:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 4'hf);
      `CHK(q, e)
   endtask

   task automatic chk_resets;
      for (int i = 0; i < 5; i++) begin
         rd_chk(ra[i], rv[i]);
      end
   endtask

   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Hang guard, far beyond the few hundred cycles the tests need
   initial begin
      #(25 * 40000);
      n_mismatch++;
      report_and_stop();
   end

   // Main sequence
   initial begin
      logic [2:0] te;
      logic [15:0] de;
      logic [1:0] v;
      ra = '{clrm_pkg::TRIG_OFS, clrm_pkg::DAC_OFS, clrm_pkg::FMUX_OFS,
         clrm_pkg::KCA_OFS, clrm_pkg::KCB_OFS};
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      chk_resets();
      // All ones: only defined fields hold, reserved bits read zero
      for (int i = 0; i < 5; i++) begin
         wr(ra[i], 32'hffffffff);
         rd_chk(ra[i], rm[i]);
      end
      rd_chk(20'h20030, 32'h0);
      // Each enable bit passes only its own modulator to its own front end
      for (int b = 0; b < 12; b++) begin
         wr(clrm_pkg::TRIG_OFS, 32'h1 << b);
         for (int p = 0; p < 4; p++) begin
            @(posedge ref_clk);
            trig_req <= 4'h1 << p;
            #1;
            te = 3'h0;
            te[b / 4] = (b % 4 == p);
            `CHK(fe_trig_out, te)
         end
      end
      // Enables clear: own front end wins whatever the code says
      wr(clrm_pkg::DAC_OFS, 32'h06060600);
      for (int n = 0; n < 3; n++) begin
         `CHK(dac_setpoint[n], 16'h1a00 + 16'(n))
      end
      // Every setpoint code on all three DACs
      for (int c = 0; c < 8; c++) begin
         wr(clrm_pkg::DAC_OFS, {{3{8'(c)}}, 8'h07});
         for (int n = 0; n < 3; n++) begin
            if (c == n || c == 7) de = 16'h0;
            else if (c < 3) de = 16'h1a00 + 16'(c);
            else if (c == 3) de = 16'h3c3c;
            else de = 16'h4b00 + 16'(c - 4);
            `CHK(dac_setpoint[n], de)
         end
      end
      wr(clrm_pkg::KCA_OFS, 32'h12340abc);
      wr(clrm_pkg::KCB_OFS, 32'h00002345);
      // Every code of every filter field at once
      for (int k = 0; k < 4; k++) begin
         v = 2'(k);
         wr(clrm_pkg::FMUX_OFS, {2'b0, {3{v}}, 5'b0, {3{v[0]}}, 2'b0,
            {3{v}}, 2'b0, {3{v}}});
         for (int f = 0; f < 3; f++) begin
            de = (k == 3) ? 16'h0 : 16'h5d00 + 16'(k);
            `CHK(filter_fe_data[f], de)
            `CHK(filter_period[f], 18'h2e000 + 18'(k))
            de = (k == 0) ? 16'h0abc : (k == 1) ? 16'h1234 :
               (k == 2) ? 16'h2345 : 16'h0;
            `CHK(filter_kcomp[f], de[13:0])
         end
         `CHK(filter_ffwd[0], v[0] ? 16'h4b02 : 16'h4b01)
         `CHK(filter_ffwd[1], v[0] ? 16'h4b02 : 16'h4b00)
         `CHK(filter_ffwd[2], v[0] ? 16'h4b01 : 16'h4b00)
      end
      // Upper lanes only: constant 1 cleared, constant 0 kept
      bus(1'b1, clrm_pkg::KCA_OFS, 32'h0, 4'hc);
      rd_chk(clrm_pkg::KCA_OFS, 32'h00000abc);
      // Second reset in mid-run with triggers still high
      @(posedge ref_clk);
      srst <= 1'b1;
      trig_req <= 4'hf;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      #1;
      `CHK(fe_trig_out, 3'h0)
      chk_resets();
      report_and_stop();
   end
endmodule
